//--- board_power_up_sequencer.sv
`include "power_seq_params.svh"
`default_nettype none
module board_power_up_sequencer
  import power_seq_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_chassis_mode,
  input  wire logic i_power_hotswap_switch,
  input  wire logic i_main_12v_good,
  input  wire logic i_pg_1v2,
  input  wire logic i_pg_1v8,
  input  wire logic i_pg_1v1_dsp,
  input  wire logic i_pg_1v1_fpga,
  output logic      o_en_chain1,
  output logic      o_en_chain3,
  output logic      o_en_1v1_dsp,
  output logic      o_en_1v1_fpga,
  output logic      o_board_rstn
);
  // Sequencer state and its next value
  seq_state_type state_r;
  seq_state_type state_nxt;

  // Carrier between the controller and the core-delay timer
  delay_timer_if tmr_if ();

  // Output flip-flops and their next values
  logic          en_chain1_r;
  logic          en_chain3_r;
  logic          en_dsp_r;
  logic          en_fpga_r;
  logic          board_rstn_r;
  logic          en_chain1_nxt;
  logic          en_chain3_nxt;
  logic          en_dsp_nxt;
  logic          en_fpga_nxt;
  logic          board_rstn_nxt;

  // switch meaning
  // Standalone: the switch is the power request.
  // Chassis: the same switch reads as the handle state.
  // Both readings share one polarity, so high always means go.
  wire           switch_on    = i_power_hotswap_switch;
  wire           power_req    = !i_chassis_mode && switch_on;
  wire           handle_shut  = i_chassis_mode && switch_on;
  wire           mode_ok      = power_req || handle_shut;

  // idle gate
  // Nothing starts until +12V is present and the switch says go
  wire           go           = i_main_12v_good && mode_ok;

  // Power-good summary of the two core rails
  wire           core_good    = i_pg_1v1_dsp && i_pg_1v1_fpga;

  // State decodes used by the transition logic
  wire           in_idle      = (state_r == ST_IDLE);
  wire           in_chain1    = (state_r == ST_CHAIN1);
  wire           in_chain3    = (state_r == ST_CHAIN3);
  wire           in_core_wait = (state_r == ST_CORE_WAIT);
  wire           in_core_on   = (state_r == ST_CORE_ON);
  wire           in_run       = (state_r == ST_RUN);

  // Transition conditions, one per arc of the machine
  // Power-good inputs are only looked at in the state that expects
  // them, so a late or early indication cannot skip a stage.
  wire           up_chain1    = in_idle && go;
  wire           up_chain3    = in_chain1 && i_pg_1v2;
  wire           up_wait      = in_chain3 && i_pg_1v8;
  wire           wait_lost    = in_core_wait && !i_pg_1v8;
  wire           up_core      = in_core_wait && i_pg_1v8 && tmr_if.done;
  wire           up_run       = in_core_on && core_good;
  wire           core_lost    = in_run && !core_good;

  // core delay
  // The timer runs only while the wait state holds; leaving the
  // state reloads it, so a dip of the 1.8V rail restarts the wait.
  assign tmr_if.start = in_core_wait;

  // Core-delay timer
  delay_timer delay_timer_i (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .tmr    (tmr_if.timer)
  );

  // Next-state selection
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (up_chain1) begin
          state_nxt = ST_CHAIN1;
        end
      end
      ST_CHAIN1: begin
        if (up_chain3) begin
          state_nxt = ST_CHAIN3;
        end
      end
      ST_CHAIN3: begin
        // Wait for the 1.8V rail before timing
        if (up_wait) begin
          state_nxt = ST_CORE_WAIT;
        end
      end
      ST_CORE_WAIT: begin
        // A lost 1.8V rail goes back to waiting for it
        if (wait_lost) begin
          state_nxt = ST_CHAIN3;
        end else if (up_core) begin
          state_nxt = ST_CORE_ON;
        end
      end
      ST_CORE_ON: begin
        if (up_run) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        // A core rail fault re-asserts the board resets
        if (core_lost) begin
          state_nxt = ST_CORE_ON;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // off drops
    // Switch off or +12V loss wins over every other arc
    if (!go) begin
      state_nxt = ST_IDLE;
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Next-state decodes for the core stage
  wire           next_core_on = (state_nxt == ST_CORE_ON);
  wire           next_run     = (state_nxt == ST_RUN);

  // Output next values, decoded from the next state so that each
  // enable changes on the same edge as the state it belongs to
  // enables and board reset
  assign en_chain1_nxt  = (state_nxt != ST_IDLE);
  assign en_chain3_nxt  = en_chain1_nxt && (state_nxt != ST_CHAIN1);
  assign en_dsp_nxt     = next_core_on || next_run;
  assign en_fpga_nxt    = next_core_on || next_run;
  assign board_rstn_nxt = next_run;

  // First chain enable
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_chain1_r <= `RAIL_EN_RST;
    end else begin
      en_chain1_r <= en_chain1_nxt;
    end
  end

  // Third chain enable
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_chain3_r <= `RAIL_EN_RST;
    end else begin
      en_chain3_r <= en_chain3_nxt;
    end
  end

  // Signal-processor core rail enable
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_dsp_r <= `RAIL_EN_RST;
    end else begin
      en_dsp_r <= en_dsp_nxt;
    end
  end

  // Programmable-logic core rail enable
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_fpga_r <= `RAIL_EN_RST;
    end else begin
      en_fpga_r <= en_fpga_nxt;
    end
  end

  // Board reset, held low until both core rails are good
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      board_rstn_r <= `BOARD_RSTN_RST;
    end else begin
      board_rstn_r <= board_rstn_nxt;
    end
  end

  // Outputs straight from their flip-flops, free of glitches
  assign o_en_chain1   = en_chain1_r;
  assign o_en_chain3   = en_chain3_r;
  assign o_en_1v1_dsp  = en_dsp_r;
  assign o_en_1v1_fpga = en_fpga_r;
  assign o_board_rstn  = board_rstn_r;
endmodule
`default_nettype wire

//--- power_seq_params.svh
// Overview of operation
// - Idle with rails off until 12V and switch on
// - 12V good and switch on: first chain
// - 1.2V good enables third chain
// - 1.8V good for the core delay enables both 1.1V rails
// - Mode selects switch meaning: power or handle
`ifndef POWER_SEQ_PARAMS_SVH
`define POWER_SEQ_PARAMS_SVH

// Clock period in nanoseconds (20 MHz)
`define CLK_PERIOD_NS      50
// Least wait from 1.8V good to core enables, microseconds
`define DSP_CORE_DELAY_US  500
// Cycle count, rounded up
`define DSP_CORE_DELAY_CYC \
  ((`DSP_CORE_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Counter width
`define DELAY_CNT_W        14
// Reset values of enable and reset outputs
`define RAIL_EN_RST        1'b0
`define BOARD_RSTN_RST     1'b0

`endif

//--- power_seq_pkg.sv
`default_nettype none
package power_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHAIN1,
    ST_CHAIN3,
    ST_CORE_WAIT,
    ST_CORE_ON,
    ST_RUN
  } seq_state_type;
endpackage
`default_nettype wire

//--- delay_timer_if.sv
`default_nettype none
interface delay_timer_if;
  logic start;
  logic done;
  modport ctrl  (output start, input done);
  modport timer (input start, output done);
endinterface
`default_nettype wire

//--- delay_timer.sv
`include "power_seq_params.svh"
`default_nettype none
module delay_timer (
  input  wire logic     i_clk,
  input  wire logic     i_rstn,
  delay_timer_if.timer  tmr
);
  localparam logic [`DELAY_CNT_W-1:0] LOAD =
    `DELAY_CNT_W'(`DSP_CORE_DELAY_CYC - 1);

  logic [`DELAY_CNT_W-1:0] cnt_r;
  logic                    run_r;
  wire                     at_zero = (cnt_r == '0);

  // Counts down from load while started; done once it reaches zero
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (!tmr.start) begin
      cnt_r <= LOAD;
      run_r <= 1'b0;
    end else begin
      run_r <= 1'b1;
      if (!at_zero) cnt_r <= cnt_r - 1'b1;
    end
  end

  assign tmr.done = run_r && at_zero;
endmodule
`default_nettype wire

//--- power_seq_chk_assertions.sv
`include "power_seq_params.svh"
`default_nettype none
module seq_chk (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_main_12v_good,
  input wire logic i_power_hotswap_switch,
  input wire logic i_pg_1v2,
  input wire logic i_pg_1v8,
  input wire logic o_en_chain1,
  input wire logic o_en_chain3,
  input wire logic o_en_1v1_dsp,
  input wire logic o_en_1v1_fpga,
  input wire logic o_board_rstn
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk);endclocking
  default disable iff (!i_rstn);
  wire go = i_main_12v_good & i_power_hotswap_switch;
  // Cycles for which 1.8V has stood good, saturating
  logic [`DELAY_CNT_W-1:0] pg8_cnt;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) pg8_cnt <= '0;
    else if (!i_pg_1v8) pg8_cnt <= '0;
    else if (pg8_cnt != '1) pg8_cnt <= pg8_cnt + 1'b1;
  end
  sequence s_c3_rise;$rose(o_en_chain3);endsequence
  sequence s_core_rise;$rose(o_en_1v1_dsp);endsequence
  property p_up;go && !o_en_chain1 |=> o_en_chain1;endproperty
  a_up: assert property(p_up) else $error("no chain1");
  property p_off;!go |=> !(o_en_chain1 | o_en_1v1_dsp);endproperty
  a_off: assert property(p_off) else $error("rail on");
  property p_c3;s_c3_rise |-> $past(i_pg_1v2);endproperty
  a_c3: assert property(p_c3) else $error("chain3 early");
  property p_rs;o_board_rstn |-> o_en_1v1_dsp;endproperty
  a_rs: assert property(p_rs) else $error("reset early");
  property p_core;s_core_rise |-> pg8_cnt >= `DSP_CORE_DELAY_CYC;endproperty
  a_core: assert property(p_core) else $error("core early");
  property p_pair;o_en_1v1_dsp == o_en_1v1_fpga;endproperty
  a_pair: assert property(p_pair) else $error("core split");
  property p_order;o_en_chain3 |-> o_en_chain1;endproperty
  a_order: assert property(p_order) else $error("order");
  property p_mode;$rose(o_en_chain1) |-> $past(go);endproperty
  a_mode: assert property(p_mode) else $error("no request");
endmodule
bind board_power_up_sequencer seq_chk seq_chk_i(.*);
`default_nettype wire

//--- rail_model.sv
`default_nettype none
// Regulators report good one cycle after enable
module rail_model(input wire logic c,e1,e3,ed,ef,
  output logic p2,p8,pd,pf);
  timeunit 1ns;timeprecision 1ns;
  always @(posedge c) {p2,p8,pd,pf} <= {e1,e3,ed,ef};
endmodule
`default_nettype wire

//--- board_power_up_sequencer_tb.sv
`include "power_seq_params.svh"
`default_nettype none
module board_power_up_sequencer_tb;
  timeunit 1ns;timeprecision 1ns;
  logic c=0,rn=0,md=0,sw=0,g=0,e1,e3,ed,ef,rs,p2,p8,pd,pf;
  int err_total,total_checks,n,cyc;
  logic [31:0] lf=32'h766B;
`define CHK(a,b) begin total_checks++; if ((a)!==(b)) begin err_total++;\
 $display("mismatch t=%0t %h %h",$time,a,b); end end
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0],v[31]^v[21]^v[1]^v[0]};
  endfunction
  initial forever #25 c=~c;
  board_power_up_sequencer board_power_up_sequencer_i(.i_clk(c),
    .i_rstn(rn),.i_chassis_mode(md),.i_power_hotswap_switch(sw),
    .i_main_12v_good(g),.i_pg_1v2(p2),.i_pg_1v8(p8),.i_pg_1v1_dsp(pd),
    .i_pg_1v1_fpga(pf),.o_en_chain1(e1),.o_en_chain3(e3),
    .o_en_1v1_dsp(ed),.o_en_1v1_fpga(ef),.o_board_rstn(rs));
  rail_model rail_model_i(.c(c),.e1(e1),.e3(e3),.ed(ed),.ef(ef),
    .p2(p2),.p8(p8),.pd(pd),.pf(pf));
  task give_verdict;
    $display("checks %0d errors %0d",total_checks,err_total);
    if (err_total==0 && total_checks>0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Cycle ceiling cuts a hang short
  always @(posedge c) if (++cyc>25000) begin err_total++;give_verdict;end
  initial begin
    repeat(4) @(posedge c);
    rn<=1;
    for (int i=0;i<2;i++) begin
      lf=lfsr_next(lf);
      @(posedge c) begin md<=i[0];g<=lf[1];end
      repeat(3) @(posedge c) #1;
      `CHK({e1,e3,ed},3'h0)
      @(posedge c) begin g<=1;sw<=1;end
      @(posedge c) #1;
      `CHK(e1,1'b1)
      `CHK(e3,1'b0)
      while (!p8) @(posedge c) #1;
      n=0;
      while (!ed) begin @(posedge c) #1; n++; end
      `CHK(n inside {[`DSP_CORE_DELAY_CYC+1:`DSP_CORE_DELAY_CYC+2]},1)
      `CHK({ed,ef,rs},3'h6)
      repeat(2) @(posedge c) #1;
      `CHK(rs,1'b1)
      @(posedge c) sw<=0;
      @(posedge c) #1;
      `CHK({e1,e3,ed,ef,rs},5'h00)
    end
    give_verdict;
  end
endmodule
`default_nettype wire
